// [pkg/cec_pkg.sv]
// Package with register map, field positions and encodings of the comparator event conditioner.
package cec_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [11:0] CEC_CTRL_OFFSET = 12'h000;
    localparam logic [11:0] CEC_STATUS_OFFSET = 12'h004;

    // Control register field positions.
    localparam int CEC_INVERT_BIT = 1;
    localparam int CEC_INT_SENSE_LSB = 2;
    localparam int CEC_INT_LEVEL_BIT = 4;
    localparam int CEC_TRIG_SENSE_LSB = 5;
    localparam int CEC_TRIG_LEVEL_BIT = 7;
    localparam int CEC_TRIG_FWD_BIT = 11;

    // Status register field positions.
    localparam int CEC_RAW_BIT = 0;
    localparam int CEC_COND_BIT = 1;
    localparam int CEC_IRQ_BIT = 2;
    localparam int CEC_ADC_BIT = 3;

    // Writable bits of the control register and its value after reset.
    localparam logic [31:0] CEC_CTRL_MASK = 32'h0000_08fe;
    localparam logic [31:0] CEC_CTRL_RESET = 32'h0000_0000;

    // Sense selection encodings.
    localparam logic [1:0] CEC_SENSE_LEVEL = 2'h0;
    localparam logic [1:0] CEC_SENSE_FALL = 2'h1;
    localparam logic [1:0] CEC_SENSE_RISE = 2'h2;
    localparam logic [1:0] CEC_SENSE_BOTH = 2'h3;

endpackage

// [src/cec_edge_detect.sv]
// Edge detector on the conditioned comparator output.
`timescale 1ns/1ps

module cec_edge_detect
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic level_in,
    output logic rise_pulse,
    output logic fall_pulse
);
    import cec_pkg::*;

    logic last_level;
    logic primed;

    // Previous sample of the conditioned level, taken every clock.
    // Pulses are held off until one real sample exists, so a comparator that already
    // sits high when reset is released does not look like a rising edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_level <= 1'b0;
            primed <= 1'b0;
        end
        else
        begin
            last_level <= level_in;
            primed <= 1'b1;
        end
    end

    // Each difference between sample and previous sample is a one-cycle pulse.
    assign rise_pulse = primed & level_in & ~last_level;
    assign fall_pulse = primed & ~level_in & last_level;

endmodule

// [src/cec_sense_select.sv]
// Sense selector that turns the conditioned level and its edges into one event.
`timescale 1ns/1ps

module cec_sense_select
(
    input wire logic [1:0] sense_select,
    input wire logic level_polarity,
    input wire logic level_in,
    input wire logic rise_pulse,
    input wire logic fall_pulse,
    output logic event_out
);
    import cec_pkg::*;

    // Pick level, falling, rising or either edge as the event source.
    always_comb
    begin
        case (sense_select)
            CEC_SENSE_LEVEL: event_out = (level_in == level_polarity);
            CEC_SENSE_FALL: event_out = fall_pulse;
            CEC_SENSE_RISE: event_out = rise_pulse;
            CEC_SENSE_BOTH: event_out = rise_pulse | fall_pulse;
            default: event_out = 1'b0;
        endcase
    end

endmodule

// [src/cec_top.sv]
// Comparator event conditioner with APB control and status registers.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps

module cec_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comparator_out,
    output logic interrupt_request,
    output logic adc_trigger
);
    import cec_pkg::*;

    logic [31:0] ctrl;
    logic output_invert;
    logic [1:0] interrupt_sense_select;
    logic interrupt_level_polarity;
    logic [1:0] trigger_sense_select;
    logic trigger_level_polarity;
    logic trigger_forward_enable;
    logic cond_level;
    logic rise_pulse;
    logic fall_pulse;
    logic next_irq;
    logic next_adc_event;
    logic access;
    logic addr_ok;

    // Decode whether an offset names a mapped register.
    function automatic logic cec_mapped(input logic [11:0] addr);
        cec_mapped = (addr == CEC_CTRL_OFFSET) || (addr == CEC_STATUS_OFFSET);
    endfunction

    // Control fields taken apart from the control register.
    assign output_invert = ctrl[CEC_INVERT_BIT];
    assign interrupt_sense_select = ctrl[CEC_INT_SENSE_LSB +: 2];
    assign interrupt_level_polarity = ctrl[CEC_INT_LEVEL_BIT];
    assign trigger_sense_select = ctrl[CEC_TRIG_SENSE_LSB +: 2];
    assign trigger_level_polarity = ctrl[CEC_TRIG_LEVEL_BIT];
    assign trigger_forward_enable = ctrl[CEC_TRIG_FWD_BIT];

    // Conditioned level feeds both sense paths, so inversion happens first.
    assign cond_level = comparator_out ^ output_invert;

    cec_edge_detect u_edge
    (
        .pclk(pclk),
        .presetn(presetn),
        .level_in(cond_level),
        .rise_pulse(rise_pulse),
        .fall_pulse(fall_pulse)
    );

    // Interrupt path sense selection.
    cec_sense_select u_irq_sense
    (
        .sense_select(interrupt_sense_select),
        .level_polarity(interrupt_level_polarity),
        .level_in(cond_level),
        .rise_pulse(rise_pulse),
        .fall_pulse(fall_pulse),
        .event_out(next_irq)
    );

    // ADC trigger path sense selection.
    cec_sense_select u_adc_sense
    (
        .sense_select(trigger_sense_select),
        .level_polarity(trigger_level_polarity),
        .level_in(cond_level),
        .rise_pulse(rise_pulse),
        .fall_pulse(fall_pulse),
        .event_out(next_adc_event)
    );

    // Outputs are registered, adding one cycle of latency but keeping them glitch free.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            interrupt_request <= 1'b0;
            adc_trigger <= 1'b0;
        end
        else
        begin
            interrupt_request <= next_irq;
            adc_trigger <= next_adc_event & trigger_forward_enable;
        end
    end

    // APB access phase; the slave never inserts wait states.
    assign access = psel & penable;
    assign addr_ok = cec_mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = access & ~addr_ok;

    // Control register write; read-only bits stay zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= CEC_CTRL_RESET;
        end
        else if (access && pwrite && paddr == CEC_CTRL_OFFSET)
        begin
            ctrl <= pwdata & CEC_CTRL_MASK;
        end
    end

    // Read data is registered during the setup phase so it is valid in the access phase.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata <= 32'h0000_0000;
            if (paddr == CEC_CTRL_OFFSET)
            begin
                prdata <= ctrl;
            end
            else if (paddr == CEC_STATUS_OFFSET)
            begin
                prdata[CEC_RAW_BIT] <= comparator_out;
                prdata[CEC_COND_BIT] <= cond_level;
                prdata[CEC_IRQ_BIT] <= interrupt_request;
                prdata[CEC_ADC_BIT] <= adc_trigger;
            end
        end
    end

endmodule

// [tb/cec_comp_model.sv]
// Model of the analog comparator that feeds the conditioner.
`timescale 1ns/1ps
module cec_comp_model
(
    input wire logic pclk,
    input wire logic want,
    output logic comparator_out
);
    // The output settles on a clock edge, as a synchronised comparator would.
    initial comparator_out = 1'b0;
    always @(posedge pclk) comparator_out <= want;
endmodule

// [tb/cec_top_monitor.sv]
// Checker on the ports of the comparator event conditioner.
`timescale 1ns/1ps
module cec_top_monitor
    import cec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic comparator_out,
    input wire logic interrupt_request,
    input wire logic adc_trigger
);
    logic [31:0] ctrl;
    logic c;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow of the control word, so the outputs can be judged from the bus alone.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn) ctrl <= '0;
        else if (psel && penable && pwrite && paddr == CEC_CTRL_OFFSET)
            ctrl <= pwdata & CEC_CTRL_MASK;
    end
    assign c = comparator_out ^ ctrl[1];
    a_apb_ready: assert property (psel && penable |-> pready) else $error("No ready.");
    a_bad_addr: assert property (psel && penable && paddr > 12'h004 |-> pslverr)
        else $error("No error on unmapped address.");
    a_int_level: assert property (($stable(c) && $stable(ctrl))[*3] ##0 ctrl[3:2] == 2'h0
        && $past(presetn)
        |-> interrupt_request == (c == ctrl[4])) else $error("Bad interrupt level.");
    a_trig_level: assert property (($stable(c) && $stable(ctrl))[*3] ##0 ctrl[6:5] == 2'h0
        |-> adc_trigger == (ctrl[11] && c == ctrl[7])) else $error("Bad trigger level.");
    a_trig_gate: assert property (!ctrl[11] && !$past(ctrl[11]) |-> !adc_trigger)
        else $error("Trigger not suppressed.");
    a_pulse_one: assert property (ctrl[3:2] != 2'h0 && $stable(ctrl) && interrupt_request
        && $stable(c) ##1 $stable(ctrl) |-> !interrupt_request) else $error("Edge pulse too long.");
    a_trig_pulse: assert property (ctrl[6:5] != 2'h0 && $stable(ctrl) && adc_trigger
        && $stable(c) ##1 $stable(ctrl) |-> !adc_trigger) else $error("Trigger pulse too long.");
endmodule

// [tb/tb.sv]
// Testbench for the comparator event conditioner.
`timescale 1ns/1ps
module tb;
    import cec_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, want = 0, er;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, comparator_out, interrupt_request, adc_trigger;
    int mismatches = 0, n_compared = 0, cyc = 0, ni = 0, na = 0;
    cec_top cec_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_out(comparator_out),
        .interrupt_request(interrupt_request), .adc_trigger(adc_trigger));
    cec_comp_model cec_comp_model_inst (.pclk(pclk), .want(want),
        .comparator_out(comparator_out));
    always #12.5 pclk = ~pclk;
    // Pulse counters and the cycle ceiling that cuts a hang short.
    always @(posedge pclk)
    begin
        cyc++;
        ni += (interrupt_request === 1'b1);
        na += (adc_trigger === 1'b1);
        if (cyc == 4000)
        begin
            mismatches++;
            give_verdict();
        end
    end
    task give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One transfer; the request stands until pready is seen high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    function logic [31:0] cfg(input logic [1:0] s, input logic p, input logic i, input logic f);
        return {20'h0, f, 3'h0, p, s, p, s, i, 1'b0};
    endfunction
    task t_regs();
        apb(0, CEC_CTRL_OFFSET, 0); chk(rd, CEC_CTRL_RESET);
        apb(1, CEC_CTRL_OFFSET, 32'hffff_ffff); apb(0, CEC_CTRL_OFFSET, 0);
        chk(rd, CEC_CTRL_MASK);
        apb(0, 12'h008, 0);
        chk(er, 1'b1);
        chk(rd, 32'h0000_0000);
        $display("Register test done");
    endtask
    task t_level();
        for (int k = 0; k < 8; k++)
        begin
            apb(1, CEC_CTRL_OFFSET, cfg(2'h0, k[0], k[1], 1'b1));
            @(posedge pclk) want <= k[2];
            wt(4);
            chk(interrupt_request, (k[2] ^ k[1]) == k[0]);
            chk(adc_trigger, (k[2] ^ k[1]) == k[0]);
        end
        $display("Level test done");
    endtask
    task t_edges();
        for (int s = 1; s < 4; s++)
        begin
            apb(1, CEC_CTRL_OFFSET, cfg(s[1:0], 1'b0, 1'b0, 1'b1));
            @(posedge pclk) want <= 0;
            wt(5); ni = 0; na = 0;
            @(posedge pclk) want <= 1;
            wt(5);
            chk(ni, s != 1);
            chk(na, s != 1);
            @(posedge pclk) want <= 0;
            wt(5);
            chk(ni, (s == 3) ? 2 : 1);
            chk(na, (s == 3) ? 2 : 1);
        end
        $display("Edge test done");
    endtask
    task t_gate();
        apb(1, CEC_CTRL_OFFSET, cfg(2'h0, 1'b1, 1'b0, 1'b0));
        @(posedge pclk) want <= 1;
        wt(4); na = 0; wt(4);
        chk({interrupt_request, adc_trigger, na[3:0]}, 6'h20);
        apb(0, CEC_STATUS_OFFSET, 0);
        chk({er, rd[3:0]}, 5'h07);
        $display("Gate test done");
    endtask
    // Main sequence.
    initial
    begin
        wt(2);
        presetn <= 1;
        t_regs();
        t_level();
        t_edges();
        t_gate();
        give_verdict();
    end
endmodule
bind cec_top cec_top_monitor cec_top_monitor_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .comparator_out(comparator_out),
    .interrupt_request(interrupt_request), .adc_trigger(adc_trigger));
